/* rtl/i2c_pkg.sv */
// Notes on behaviour
// - serial clock anywhere from zero to 1000 kHz
// - hold clock low until read data ready
// - lines only pulled low, otherwise released
// - address 0x44 when select low, else 0x45
// - address follows select, stable during transfer
// - upper seven bits address, low bit direction
// - alert high while readings break limits
// - reset after pin low at least 1 us
// - acknowledge each byte after eighth falling edge
package i2c_pkg;

    localparam logic [6:0] ADDR_SEL_LOW  = 7'h44;
    localparam logic [6:0] ADDR_SEL_HIGH = 7'h45;
    localparam int         SCL_MAX_KHZ   = 1000;
    localparam int         LINK_CLK_NS   = 125;   // oversampling clock of the pin logic
    localparam int         CLK_MHZ       = 250;
    localparam int         RST_MIN_NS    = 1000;
    // least time: rounded up to whole cycles
    localparam int         RST_MIN_CYC   = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int         RW_BIT        = 0;
    localparam logic [7:0] IDLE_BYTE     = 8'hFF;

    typedef enum logic [5:0] {
        ST_IDLE    = 6'b00_0001,
        ST_RECV    = 6'b00_0010,
        ST_ACK     = 6'b00_0100,
        ST_STRETCH = 6'b00_1000,
        ST_SEND    = 6'b01_0000,
        ST_RACK    = 6'b10_0000
    } link_state_e;

endpackage

/* rtl/pin_sync.sv */
////////////////////////////////////////////////////////////////////////////////
// two-stage synchroniser, first stage feeds only the second
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    // no reset: value settles after two edges
    always_ff @(posedge clk_i) begin
        meta_reg <= d_i;
        q_o      <= meta_reg;
    end
endmodule

/* rtl/i2c_sensor_target.sv */
////////////////////////////////////////////////////////////////////////////////
// sensor bus target: pin logic on link_clk_i, reset filter and alert on clk_i
module i2c_sensor_target (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        link_clk_i,
    input  wire logic        reset_in_n_i,
    input  wire logic        addr_sel_i,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe_o,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    input  wire logic [15:0] humidity_i,
    input  wire logic [15:0] temperature_i,
    input  wire logic [15:0] hum_hi_i,
    input  wire logic [15:0] hum_lo_i,
    input  wire logic [15:0] temp_hi_i,
    input  wire logic [15:0] temp_lo_i,
    output logic             alert_o,
    output logic             dev_rst_o,
    input  wire logic        stretch_en_i,
    input  wire logic        tx_load_i,
    input  wire logic [7:0]  tx_data_i,
    output logic             tx_full_o,
    output logic [7:0]       rx_data_o,
    output logic             rx_valid_o
);
    ////////////////////////////////////////////////////////////////////////////
    // core domain: reset pin filter
    logic       rst_pin_n_s;
    logic [8:0] rst_cnt_reg;
    wire        core_rst = rst_i | dev_rst_o;
    wire        rst_cnt_full = (rst_cnt_reg == 9'(i2c_pkg::RST_MIN_CYC));

    pin_sync #(.W(1)) u_rst_sync (.clk_i(clk_i), .d_i(reset_in_n_i), .q_o(rst_pin_n_s));

    // count low cycles; short glitches never reach the device reset
    always_ff @(posedge clk_i) begin
        if (rst_i || rst_pin_n_s) begin
            rst_cnt_reg <= 9'h000;
            dev_rst_o   <= 1'b0;
        end else if (!rst_cnt_full) begin
            rst_cnt_reg <= rst_cnt_reg + 9'h001;
        end else begin
            dev_rst_o   <= 1'b1;
        end
    end

    AST_RST_MIN: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(dev_rst_o) |-> $past(!rst_pin_n_s, i2c_pkg::RST_MIN_CYC))
        else $error("device reset after too short a pulse");

    ////////////////////////////////////////////////////////////////////////////
    // core domain: alert comparison
    wire alert_cond = (humidity_i > hum_hi_i) || (humidity_i < hum_lo_i) ||
                      (temperature_i > temp_hi_i) || (temperature_i < temp_lo_i);

    always_ff @(posedge clk_i) begin
        if (core_rst) alert_o <= 1'b0;
        else          alert_o <= alert_cond;
    end

    AST_ALERT: assert property (@(posedge clk_i) disable iff (core_rst)
        alert_cond ##1 alert_cond |-> alert_o)
        else $error("alert low while limits are broken");

    ////////////////////////////////////////////////////////////////////////////
    // core domain: transmit buffer and receive toggle handshakes
    logic [7:0] tx_buf_reg;
    logic       tx_req_reg;
    logic       tx_ack_s;
    logic       rx_tgl_s;
    logic       rx_tgl_q_reg;
    logic [7:0] rx_hold_reg;
    logic       rx_tgl_reg;
    logic       tx_ack_reg;
    logic       link_rst_s;
    wire        hs_rst = core_rst | link_rst_s; // waits for link reset: no stale toggle

    pin_sync #(.W(1)) u_txack_sync (.clk_i(clk_i), .d_i(tx_ack_reg), .q_o(tx_ack_s));
    pin_sync #(.W(1)) u_rxtgl_sync (.clk_i(clk_i), .d_i(rx_tgl_reg), .q_o(rx_tgl_s));

    // buffer stays frozen while full, so the link may read it at leisure
    always_ff @(posedge clk_i) begin
        if (hs_rst) begin
            tx_buf_reg <= i2c_pkg::IDLE_BYTE;
            tx_req_reg <= 1'b0;
            tx_full_o  <= 1'b0;
        end else if (tx_load_i && !tx_full_o) begin
            tx_buf_reg <= tx_data_i;
            tx_req_reg <= ~tx_req_reg;
            tx_full_o  <= 1'b1;
        end else begin
            tx_full_o  <= tx_full_o && (tx_ack_s != tx_req_reg);
        end
    end

    // received byte is held stable by the link for a whole byte time
    always_ff @(posedge clk_i) begin
        if (hs_rst) begin
            rx_tgl_q_reg <= 1'b0;
            rx_valid_o   <= 1'b0;
            rx_data_o    <= 8'h00;
        end else begin
            rx_tgl_q_reg <= rx_tgl_s;
            rx_valid_o   <= rx_tgl_s != rx_tgl_q_reg;
            if (rx_tgl_s != rx_tgl_q_reg) rx_data_o <= rx_hold_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link domain: reset and pin synchronisers
    logic       link_rst;
    logic       scl_s;
    logic       sda_s;
    logic       addr_s;
    logic       tx_req_s;
    logic       stretch_s;
    logic       scl_q_reg;
    logic       sda_q_reg;

    pin_sync #(.W(1)) u_lrst_sync (.clk_i(link_clk_i), .d_i(core_rst), .q_o(link_rst));
    pin_sync #(.W(1)) u_lrst_back (.clk_i(clk_i), .d_i(link_rst), .q_o(link_rst_s));
    wire        link_off = rst_i | link_rst; // rst_i covers the first, unknown link edges
    pin_sync #(.W(5)) u_pin_sync (
        .clk_i (link_clk_i),
        .d_i   ({scl_i, sda_i, addr_sel_i, tx_req_reg, stretch_en_i}),
        .q_o   ({scl_s, sda_s, addr_s, tx_req_s, stretch_s})
    );

    // oversampling at 8 MHz leaves ~4 samples per phase at the 1 MHz limit
    always_ff @(posedge link_clk_i) begin
        scl_q_reg <= scl_s;
        sda_q_reg <= sda_s;
    end

    wire scl_rise  = scl_s && !scl_q_reg;
    wire scl_fall  = !scl_s && scl_q_reg;
    wire start_det = scl_s && scl_q_reg && sda_q_reg && !sda_s;
    wire stop_det  = scl_s && scl_q_reg && !sda_q_reg && sda_s;

    ////////////////////////////////////////////////////////////////////////////
    // link domain: byte engine
    i2c_pkg::link_state_e state_reg;
    logic [7:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic       hdr_reg;
    logic       rw_reg;
    logic       nack_reg;
    logic [6:0] my_addr_reg;

    wire        byte_done = scl_fall && (bit_cnt_reg == i2c_pkg::BITS_PER_BYTE);
    wire        addr_hit  = shift_reg[7:1] == my_addr_reg;
    wire        tx_avail  = tx_req_s != tx_ack_reg;
    wire        hold_scl  = stretch_s && !tx_avail;

    // drivers only ever pull low: the driven level is a constant zero
    always_ff @(posedge link_clk_i) begin
        scl_o <= 1'b0;
        sda_o <= 1'b0;
    end

    // load the next read byte; clock is let go one cycle later, in send
    task automatic load_byte();
        shift_reg <= tx_buf_reg;
        sda_oe_o  <= !tx_buf_reg[7];
        bit_cnt_reg <= 4'h0;
        state_reg <= i2c_pkg::ST_SEND;
        if (tx_avail) tx_ack_reg <= ~tx_ack_reg;
    endtask

    always_ff @(posedge link_clk_i) begin
        if (link_rst) begin
            state_reg   <= i2c_pkg::ST_IDLE;
            shift_reg   <= 8'h00;
            bit_cnt_reg <= 4'h0;
            hdr_reg     <= 1'b0;
            rw_reg      <= 1'b0;
            nack_reg    <= 1'b0;
            my_addr_reg <= i2c_pkg::ADDR_SEL_LOW;
            scl_oe_o    <= 1'b0;
            sda_oe_o    <= 1'b0;
            tx_ack_reg  <= 1'b0;
            rx_tgl_reg  <= 1'b0;
            rx_hold_reg <= 8'h00;
        end else if (start_det) begin
            // select level is taken at each start, held to the end
            my_addr_reg <= addr_s ? i2c_pkg::ADDR_SEL_HIGH
                                  : i2c_pkg::ADDR_SEL_LOW;
            state_reg   <= i2c_pkg::ST_RECV;
            bit_cnt_reg <= 4'h0;
            hdr_reg     <= 1'b1;
            scl_oe_o    <= 1'b0;
            sda_oe_o    <= 1'b0;
        end else if (stop_det) begin
            state_reg   <= i2c_pkg::ST_IDLE;
            scl_oe_o    <= 1'b0;
            sda_oe_o    <= 1'b0;
        end else begin
            unique case (state_reg)
                i2c_pkg::ST_IDLE: begin
                    sda_oe_o <= 1'b0;
                end
                i2c_pkg::ST_RECV: begin
                    if (scl_rise) begin
                        shift_reg   <= {shift_reg[6:0], sda_s};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (byte_done && hdr_reg && !addr_hit) begin
                        state_reg <= i2c_pkg::ST_IDLE;
                    end else if (byte_done) begin
                        sda_oe_o  <= 1'b1;
                        state_reg <= i2c_pkg::ST_ACK;
                        if (hdr_reg) begin
                            rw_reg <= shift_reg[i2c_pkg::RW_BIT];
                        end else begin
                            rx_hold_reg <= shift_reg;
                            rx_tgl_reg  <= ~rx_tgl_reg;
                        end
                    end
                end
                i2c_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        sda_oe_o    <= 1'b0;
                        hdr_reg     <= 1'b0;
                        bit_cnt_reg <= 4'h0;
                        if (!rw_reg) begin
                            state_reg <= i2c_pkg::ST_RECV;
                        end else if (hold_scl) begin
                            scl_oe_o  <= 1'b1;
                            state_reg <= i2c_pkg::ST_STRETCH;
                        end else begin
                            load_byte();
                        end
                    end
                end
                i2c_pkg::ST_STRETCH: begin
                    if (!hold_scl) load_byte();
                end
                i2c_pkg::ST_SEND: begin
                    scl_oe_o <= 1'b0;                      // data settles first
                    if (scl_fall && bit_cnt_reg == 4'h7) begin
                        sda_oe_o  <= 1'b0;
                        state_reg <= i2c_pkg::ST_RACK;
                    end else if (scl_fall) begin
                        shift_reg   <= {shift_reg[6:0], 1'b1};
                        sda_oe_o    <= !shift_reg[6];
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                end
                i2c_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        nack_reg <= sda_s;
                    end else if (scl_fall && nack_reg) begin
                        state_reg <= i2c_pkg::ST_IDLE;
                    end else if (scl_fall && hold_scl) begin
                        scl_oe_o  <= 1'b1;
                        state_reg <= i2c_pkg::ST_STRETCH;
                    end else if (scl_fall) begin
                        load_byte();
                    end
                end
                default: begin
                    state_reg <= i2c_pkg::ST_IDLE;
                    scl_oe_o  <= 1'b0;
                    sda_oe_o  <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link domain checks
    AST_OPEN_DRAIN: assert property (@(posedge link_clk_i) disable iff (link_off)
        !scl_o && !sda_o)
        else $error("bus line driven high");

    AST_ADDR_VALUE: assert property (@(posedge link_clk_i) disable iff (link_off)
        start_det |=> my_addr_reg == ($past(addr_s) ? 7'h45 : 7'h44))
        else $error("wrong address for select level");

    AST_ADDR_HOLD: assert property (@(posedge link_clk_i) disable iff (link_off)
        (state_reg != i2c_pkg::ST_IDLE) && !start_det |=> $stable(my_addr_reg))
        else $error("address changed inside a transfer");

    AST_HDR_ACK: assert property (@(posedge link_clk_i) disable iff (link_off)
        state_reg == i2c_pkg::ST_RECV && byte_done && hdr_reg && addr_hit
        && !start_det && !stop_det |=> sda_oe_o && state_reg == i2c_pkg::ST_ACK)
        else $error("matching header not acknowledged");

    AST_HDR_RW: assert property (@(posedge link_clk_i) disable iff (link_off)
        state_reg == i2c_pkg::ST_RECV && byte_done && hdr_reg && addr_hit
        && !start_det && !stop_det |=> rw_reg == $past(shift_reg[0]))
        else $error("direction not taken from low header bit");

    AST_NACK: assert property (@(posedge link_clk_i) disable iff (link_off)
        state_reg == i2c_pkg::ST_RECV && byte_done && hdr_reg && !addr_hit
        && !start_det |=> !sda_oe_o ##1 !sda_oe_o && !scl_oe_o)
        else $error("foreign header disturbed the bus");

    AST_STRETCH: assert property (@(posedge link_clk_i) disable iff (link_off)
        state_reg == i2c_pkg::ST_STRETCH |-> scl_oe_o)
        else $error("clock not held during stretch");

    AST_ACK_END: assert property (@(posedge link_clk_i) disable iff (link_off)
        state_reg == i2c_pkg::ST_ACK && scl_fall && !rw_reg && !start_det && !stop_det
        |=> !sda_oe_o && state_reg == i2c_pkg::ST_RECV)
        else $error("acknowledge not released after its clock");

endmodule

/* verification/i2c_master_model.sv */
////////////////////////////////////////////////////////////////////////////////
// bus master: open-drain scl/sda, paced by negedges of the core clock
module i2c_master_model (
    input  wire logic clk_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      scl_oe_o,
    output logic      sda_oe_o
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF_CYC = 150; // 600 ns high, 760 ns low, about 735 kHz
    localparam int GAP_CYC  = 40;  // data waits after scl fall so no false start or stop
    int stalls = 0;
    initial begin
        scl_oe_o = 1'b0; // released at rest
        sda_oe_o = 1'b0;
    end
    task automatic hp();
        repeat (HALF_CYC) @(negedge clk_i);
    endtask
    // release scl, then wait out a target that holds it low
    task automatic scl_high();
        int n;
        n = 0;
        scl_oe_o = 1'b0; // only ever pulled low
        @(negedge clk_i);
        while (scl_i !== 1'b1 && n < 20000) begin
            @(negedge clk_i);
            n++;
        end
        if (n > 0) stalls++;
        hp();
    endtask
    // one bit: b high means release sda, s is the level sampled late in the high phase
    task automatic bit_io(input logic b, output logic s);
        sda_oe_o = ~b;
        hp();
        scl_high();
        s = sda_i;
        scl_oe_o = 1'b1;
        repeat (GAP_CYC) @(negedge clk_i);
    endtask
    task automatic start();
        sda_oe_o = 1'b1;
        hp();
        scl_oe_o = 1'b1;
        repeat (GAP_CYC) @(negedge clk_i);
    endtask
    task automatic stop();
        sda_oe_o = 1'b1;
        hp();
        scl_high();
        sda_oe_o = 1'b0;
        hp();
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s); // msb first
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(~mack, s);
    endtask
endmodule

/* verification/i2c_sensor_target_tb_top.sv */
////////////////////////////////////////////////////////////////////////////////
module i2c_sensor_target_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_i = 1'b0;
    logic        link_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        reset_in_n_i = 1'b1;
    logic        addr_sel_i = 1'b0;
    logic        stretch_en_i = 1'b0;
    logic        tx_load_i = 1'b0;
    logic [7:0]  tx_data_i = 8'h00;
    logic [15:0] humidity_i = 16'h0000;
    logic [15:0] temperature_i = 16'h0000;
    logic [15:0] hum_hi_i = 16'h03E8;
    logic [15:0] hum_lo_i = 16'h0064;
    logic [15:0] temp_hi_i = 16'h07D0;
    logic [15:0] temp_lo_i = 16'h00C8;
    logic        scl_o, scl_oe_o, sda_o, sda_oe_o, m_scl_oe, m_sda_oe;
    logic        alert_o, dev_rst_o, tx_full_o, rx_valid_o;
    logic [7:0]  rx_data_o, rx_last;
    logic        any_oe = 1'b0;
    logic        stretch_seen = 1'b0;
    int          rx_cnt = 0;
    int          n_mismatch = 0;
    int          checks = 0;
    wire         scl = !(m_scl_oe || scl_oe_o); // pull-up when nobody pulls
    wire         sda = !(m_sda_oe || sda_oe_o);
    initial forever #2 clk_i = ~clk_i;
    // link clock offset so its edges never line up with the core clock
    initial begin
        #37.3;
        forever #62.5 link_clk_i = ~link_clk_i;
    end
    i2c_sensor_target dut (.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
        .reset_in_n_i(reset_in_n_i), .addr_sel_i(addr_sel_i), .scl_i(scl), .scl_o(scl_o),
        .scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .humidity_i(humidity_i), .temperature_i(temperature_i), .hum_hi_i(hum_hi_i),
        .hum_lo_i(hum_lo_i), .temp_hi_i(temp_hi_i), .temp_lo_i(temp_lo_i),
        .alert_o(alert_o), .dev_rst_o(dev_rst_o), .stretch_en_i(stretch_en_i),
        .tx_load_i(tx_load_i), .tx_data_i(tx_data_i), .tx_full_o(tx_full_o),
        .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o));
    i2c_master_model m (.clk_i(clk_i), .scl_i(scl), .sda_i(sda),
        .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));
    task automatic cmp_bit(input logic e, input logic g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // monitors: received bytes, any driving, stretch, driven level
    always @(posedge clk_i) begin
        if (rx_valid_o === 1'b1) begin
            rx_cnt <= rx_cnt + 1;
            rx_last <= rx_data_o;
        end
        if (scl_oe_o === 1'b1 || sda_oe_o === 1'b1) any_oe <= 1'b1;
        if (scl_oe_o === 1'b1) stretch_seen <= 1'b1;
        if (!rst_i && (scl_oe_o || sda_oe_o)) cmp_bit(1'b0, scl_o | sda_o);
    end
    task automatic load_tx(input logic [7:0] d);
        @(negedge clk_i);
        tx_data_i = d;
        tx_load_i = 1'b1;
        @(negedge clk_i);
        tx_load_i = 1'b0;
        cmp_bit(1'b1, tx_full_o);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_write();
        logic ack;
        int   n0;
        n0 = rx_cnt;
        m.start();
        m.wbyte({i2c_pkg::ADDR_SEL_LOW, 1'b0}, ack);
        cmp_bit(1'b1, ack);
        m.wbyte(8'hA5, ack);
        cmp_bit(1'b1, ack);
        m.stop();
        repeat (20) @(negedge clk_i);
        cmp_byte(8'hA5, rx_last);
        cmp_bit(1'b1, rx_cnt == n0 + 1);
    endtask
    // select flips between transfers; old address must then be ignored
    task automatic t_addr();
        logic ack;
        int   n0;
        addr_sel_i = 1'b1; // changed only between transfers
        repeat (100) @(negedge clk_i);
        m.start();
        m.wbyte({i2c_pkg::ADDR_SEL_HIGH, 1'b0}, ack);
        cmp_bit(1'b1, ack);
        m.stop();
        n0 = rx_cnt;
        any_oe = 1'b0;
        m.start();
        m.wbyte({i2c_pkg::ADDR_SEL_LOW, 1'b0}, ack);
        cmp_bit(1'b0, ack);
        m.wbyte(8'h5A, ack);
        cmp_bit(1'b0, ack);
        m.stop();
        cmp_bit(1'b0, any_oe);
        cmp_bit(1'b1, rx_cnt == n0);
    endtask
    task automatic t_read(input logic stretch);
        logic ack;
        logic [7:0] d;
        logic [7:0] exp;
        int         s0;
        exp = stretch ? 8'hC3 : 8'h3C;
        stretch_en_i = stretch;
        if (!stretch) load_tx(exp);
        stretch_seen = 1'b0;
        s0 = m.stalls;
        fork
            begin
                m.start();
                m.wbyte({i2c_pkg::ADDR_SEL_HIGH, 1'b1}, ack);
                m.rbyte(1'b0, d);
                m.stop();
            end
            if (stretch) begin
                repeat (6000) @(negedge clk_i);
                load_tx(exp);
            end
        join
        cmp_bit(1'b1, ack);
        cmp_byte(exp, d);
        cmp_bit(stretch, stretch_seen);
        cmp_bit(stretch, m.stalls != s0);
        cmp_bit(1'b0, tx_full_o);
        stretch_en_i = 1'b0;
    endtask
    task automatic t_alert();
        logic [15:0] h[6] = '{16'h01F4, 16'h03E9, 16'h0063, 16'h01F4, 16'h01F4, 16'h03E8};
        logic [15:0] t[6] = '{16'h01F4, 16'h01F4, 16'h01F4, 16'h07D1, 16'h00C7, 16'h07D0};
        logic        e[6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 6; i++) begin
            @(negedge clk_i);
            humidity_i = h[i];
            temperature_i = t[i];
            repeat (3) @(negedge clk_i);
            cmp_bit(e[i], alert_o);
        end
    endtask
    // 200 cycles is 0.8 us, too short; 300 cycles is 1.2 us
    task automatic t_reset_pin();
        @(negedge clk_i);
        reset_in_n_i = 1'b0;
        repeat (200) @(negedge clk_i);
        cmp_bit(1'b0, dev_rst_o);
        reset_in_n_i = 1'b1;
        repeat (10) @(negedge clk_i);
        reset_in_n_i = 1'b0;
        repeat (300) @(negedge clk_i);
        cmp_bit(1'b1, dev_rst_o);
        reset_in_n_i = 1'b1;
        repeat (10) @(negedge clk_i);
        cmp_bit(1'b0, dev_rst_o);
    endtask
    task automatic summarize();
        $display("mismatches %0d of %0d checks", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // reset spans link clock cycles, since the link side resets through a synchroniser
    initial begin
        repeat (10) @(posedge link_clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        repeat (5) @(posedge link_clk_i);
        @(negedge clk_i);
        t_write();
        t_addr();
        t_read(1'b0);
        t_read(1'b1);
        t_alert();
        t_reset_pin();
        summarize();
    end
    // about 35k cycles of traffic expected
    initial begin
        #400000;
        n_mismatch++;
        summarize();
    end
endmodule
